// ==== pkg/apmc_map.svh ====
// register-map constants for the adc power mode control block
`ifndef APMC_MAP_SVH
`define APMC_MAP_SVH
`define APMC_PM_LOW_POS      0
`define APMC_PM_HIGH_POS     1
`define APMC_PM_NORMAL       2'h0
`define APMC_PM_AUTO_SHUT    2'h1
`define APMC_PM_AUTO_STBY    2'h2
`define APMC_PM_FULL_SHUT    2'h3
`define APMC_CTRL_RESET      12'h000
`define APMC_PWRUP_TIME_US   10000
`define APMC_CLK_MHZ         25
`endif

// ==== pkg/apmc_pkg.sv ====
// types shared by the adc power mode control block
package apmc_pkg;
    typedef enum logic [3:0] {
        APMC_NORMAL    = 4'b0001,
        APMC_AUTO_SHUT = 4'b0010,
        APMC_AUTO_STBY = 4'b0100,
        APMC_FULL_SHUT = 4'b1000
    } apmc_mode_t;

    typedef struct packed {
        logic        cs_n;
        logic        wr_n;
        logic [11:0] data;
    } apmc_bus_t;

    typedef struct packed {
        logic        powered_down;
        logic        hold;
        logic        power_up_busy;
        logic        power_up_done;
    } apmc_stat_t;
endpackage : apmc_pkg

// ==== src/apmc_ctrl.sv ====
// power mode control: control register capture, full shutdown and power-up timing
// Overview of operation
// - write with both mode bits one powers everything down at write strobe rise
// - full shutdown forces track-and-hold into hold for its whole duration
// - control register contents are kept unchanged during full shutdown except by an accepted write, repeat shutdown writes included
// - full shutdown persists until a later write changes the mode bits
// - write of both mode bits zero in shutdown starts power-up, returns to track
// - mode decode: 00 normal, 01 autoshutdown, 10 autostandby; normal after reset
// - control data latched on write strobe rising edge if chip select was active during the strobe low phase
`timescale 1ns/1ps
`include "apmc_map.svh"
module apmc_ctrl
    import apmc_pkg::*;
#(
    parameter int PWRUP_CYCLES = (`APMC_PWRUP_TIME_US * `APMC_CLK_MHZ)
) (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        chip_select_n,
    input  wire logic        write_n,
    input  wire logic [11:0] data_in,
    input  wire logic        conversion_start_n,
    output logic [11:0]      ctrl_reg,
    output apmc_mode_t       power_mode,
    output logic             powered_down,
    output logic             track_hold_in_hold,
    output logic             power_up_busy,
    output logic             early_conversion
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [2:0]  cs_sync;
        logic [2:0]  wr_sync;
        logic [2:0]  cv_sync;
        logic        strobe_ok;     // cs was active while strobe low
        logic [11:0] ctrl;
        apmc_mode_t  mode;
        logic        down;
        logic        hold;
        logic        busy;
        logic [31:0] cnt;
        logic        early;
    } apmc_state_t;

    apmc_state_t st_ff;
    apmc_state_t nxt_st;

    logic       wr_rise;
    logic       cv_fall;
    logic [1:0] new_pm;
    logic [1:0] pm_in;      // mode bits as they stand on the data pins, read by the checks

    // ************************************************************
    // next-state logic
    // ************************************************************
    always_comb begin
        nxt_st = st_ff;
        // three-stage sync; edges judged only on stages two and three
        nxt_st.cs_sync = {st_ff.cs_sync[1:0], chip_select_n};
        nxt_st.wr_sync = {st_ff.wr_sync[1:0], write_n};
        nxt_st.cv_sync = {st_ff.cv_sync[1:0], conversion_start_n};
        wr_rise = st_ff.wr_sync[2] == 1'b0 && st_ff.wr_sync[1] == 1'b1;
        cv_fall = st_ff.cv_sync[2] == 1'b1 && st_ff.cv_sync[1] == 1'b0;
        new_pm  = {st_ff.ctrl[`APMC_PM_HIGH_POS], st_ff.ctrl[`APMC_PM_LOW_POS]};
        // chip select qualifies the low phase; both late stages must agree before it counts
        if (st_ff.wr_sync[2:1] == 2'b00 && st_ff.cs_sync[2:1] == 2'b00) begin
            nxt_st.strobe_ok = 1'b1;
        end else if (wr_rise) begin
            nxt_st.strobe_ok = 1'b0;
        end
        // power-up timer runs down after leaving full shutdown
        if (st_ff.busy) begin
            if (st_ff.cnt <= 32'h1) begin
                nxt_st.busy = 1'b0;
                nxt_st.cnt  = 32'h0;
            end else begin
                nxt_st.cnt = st_ff.cnt - 32'h1;
            end
        end
        // conversion started too soon: data will be invalid (flagged only)
        nxt_st.early = cv_fall && st_ff.busy;
        if (wr_rise && st_ff.strobe_ok) begin
            nxt_st.ctrl = data_in;
            new_pm = {data_in[`APMC_PM_HIGH_POS], data_in[`APMC_PM_LOW_POS]};
            unique case (new_pm)
                `APMC_PM_NORMAL:    nxt_st.mode = APMC_NORMAL;
                `APMC_PM_AUTO_SHUT: nxt_st.mode = APMC_AUTO_SHUT;
                `APMC_PM_AUTO_STBY: nxt_st.mode = APMC_AUTO_STBY;
                `APMC_PM_FULL_SHUT: nxt_st.mode = APMC_FULL_SHUT;
            endcase
            if (new_pm == `APMC_PM_FULL_SHUT) begin
                // any shutdown write, repeat or not, clears the power-up timer and goes or stays down
                nxt_st.down = 1'b1;
                nxt_st.hold = 1'b1;
                nxt_st.busy = 1'b0;
                nxt_st.cnt  = 32'h0;
            end else if (st_ff.down) begin
                // any other mode ends shutdown; power-up timed from this edge
                nxt_st.down = 1'b0;
                nxt_st.hold = 1'b0;
                nxt_st.busy = 1'b1;
                nxt_st.cnt  = 32'(PWRUP_CYCLES);
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            st_ff         <= '0;
            st_ff.cs_sync <= 3'h7;
            st_ff.wr_sync <= 3'h7;
            st_ff.cv_sync <= 3'h7;
            st_ff.ctrl    <= `APMC_CTRL_RESET;
            st_ff.mode    <= APMC_NORMAL;
            st_ff.hold    <= 1'b1;        // hold after power-on until a wake from full shutdown
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from flops; ctrl changes in shutdown only on an accepted write
    assign ctrl_reg           = st_ff.ctrl;
    assign power_mode         = st_ff.mode;
    assign powered_down       = st_ff.down;
    assign track_hold_in_hold = st_ff.hold;
    assign power_up_busy      = st_ff.busy;
    assign early_conversion   = st_ff.early;

    // mode field of the incoming word, named once so the checks share one decode
    assign pm_in = {data_in[`APMC_PM_HIGH_POS], data_in[`APMC_PM_LOW_POS]};

    // ************************************************************
    // checks
    // ************************************************************
    // an accepted write: strobe rise on the synced pins, chip select having qualified it
    sequence s_taken;
        st_ff.wr_sync[2:1] == 2'b01 && st_ff.strobe_ok;
    endsequence

    sequence s_shut_write;
        st_ff.wr_sync[2:1] == 2'b01 && st_ff.strobe_ok
            && pm_in == `APMC_PM_FULL_SHUT;
    endsequence

    sequence s_wake_write;
        st_ff.wr_sync[2:1] == 2'b01 && st_ff.strobe_ok
            && pm_in == `APMC_PM_NORMAL && st_ff.down;
    endsequence

    // a strobe rise that chip select never qualified must leave no trace
    sequence s_stray_strobe;
        st_ff.wr_sync[2:1] == 2'b01 && !st_ff.strobe_ok;
    endsequence

    // entering and staying in full shutdown
    AST_SHUT_ENTRY: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_shut_write |=> powered_down && track_hold_in_hold && !power_up_busy)
        else $error("full shutdown not entered");
    AST_SHUT_MODE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_shut_write |=> power_mode == APMC_FULL_SHUT)
        else $error("full shutdown mode not shown");
    AST_HOLD_IN_SHUT: assert property (@(posedge ref_clk) disable iff (!reset_n)
        powered_down |-> track_hold_in_hold)
        else $error("track-and-hold left hold during shutdown");
    AST_CTRL_KEPT: assert property (@(posedge ref_clk) disable iff (!reset_n)
        powered_down && !(st_ff.wr_sync[2:1] == 2'b01 && st_ff.strobe_ok)
            |=> $stable(ctrl_reg))
        else $error("control register changed in shutdown");
    AST_STAY_DOWN: assert property (@(posedge ref_clk) disable iff (!reset_n)
        powered_down && !(st_ff.wr_sync[2:1] == 2'b01) |=> powered_down)
        else $error("shutdown left without a write");
    AST_BUSY_AWAKE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        power_up_busy |-> !powered_down)
        else $error("power-up running while shut down");

    // leaving full shutdown; the power-up timer may start only from there
    AST_WAKE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_wake_write |=> !powered_down && !track_hold_in_hold && power_up_busy
            && power_mode == APMC_NORMAL)
        else $error("wake from shutdown failed");
    AST_NO_IDLE_POWERUP: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !powered_down && !power_up_busy |=> !power_up_busy)
        else $error("power-up started outside full shutdown");
    AST_EARLY_FLAG: assert property (@(posedge ref_clk) disable iff (!reset_n)
        power_up_busy && st_ff.cv_sync[2:1] == 2'b10 |=> early_conversion)
        else $error("early conversion not flagged");

    // mode decode and register capture
    AST_DECODE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_taken ##0 pm_in == `APMC_PM_AUTO_SHUT |=> power_mode == APMC_AUTO_SHUT)
        else $error("autoshutdown decode wrong");
    AST_DECODE_STBY: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_taken ##0 pm_in == `APMC_PM_AUTO_STBY |=> power_mode == APMC_AUTO_STBY)
        else $error("autostandby decode wrong");
    AST_DECODE_NORMAL: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_taken ##0 pm_in == `APMC_PM_NORMAL |=> power_mode == APMC_NORMAL)
        else $error("normal mode decode wrong");
    AST_LATCH: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_taken |=> ctrl_reg == $past(data_in))
        else $error("control data not latched");
    AST_STRAY_IGNORED: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_stray_strobe |=> $stable(ctrl_reg) && $stable(power_mode))
        else $error("unselected strobe changed the register");
    AST_REWRITE_SHUT: assert property (@(posedge ref_clk) disable iff (!reset_n)
        powered_down ##0 s_shut_write |=> powered_down && !power_up_busy)
        else $error("repeat shutdown write started power-up");

endmodule : apmc_ctrl

// ==== verif/apmc_host.sv ====
// host model driving the parallel write strobe and conversion start of the block
`timescale 1ns/1ps
module apmc_host (
    input  wire logic        ref_clk,
    output logic             chip_select_n,
    output logic             write_n,
    output logic [11:0]      data_in,
    output logic             conversion_start_n
);
    // idle high before the first edge; released data is inverted so stale words never match
    initial begin
        chip_select_n      = 1'b1;
        write_n            = 1'b1;
        data_in            = 12'hFFF;
        conversion_start_n = 1'b1;
    end

    // word write: strobe low four clocks, then high six clocks, data held past the detection cycle
    task automatic write_word(input logic [11:0] d, input logic sel);
        @(posedge ref_clk);
        chip_select_n <= ~sel;
        write_n       <= 1'b0;
        data_in       <= d;
        repeat (4) @(posedge ref_clk);
        write_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chip_select_n <= 1'b1;
        data_in       <= ~d;
    endtask : write_word

    // conversion start pulse; a short wait after a wake breaks the power-up rule on purpose
    localparam int SERVICE_GAP = 4;  // clocks the host spends serving one result

    task automatic start_conv(input int wait_cycles);
        @(posedge ref_clk);
        repeat (wait_cycles) @(posedge ref_clk);
        conversion_start_n <= 1'b0;
        repeat (4) @(posedge ref_clk);
        conversion_start_n <= 1'b1;
        // the end-of-conversion request is served before another start may come
        repeat (SERVICE_GAP) @(posedge ref_clk);
    endtask : start_conv
endmodule : apmc_host

// ==== verif/tb_top.sv ====
// self-checking bench for the power mode control block
`timescale 1ns/1ps
module tb_top
    import apmc_pkg::*;
;
    localparam int PW = 20;  // short power-up count keeps the run brief
    logic ref_clk, reset_n, cs_n, wr_n, conv_n, pdown, hold, busy, early;
    logic [11:0] din, ctrl, exp_ctrl;
    apmc_mode_t mode, exp_mode;
    logic exp_shut, exp_hold, woke;
    logic [31:0] seed;
    int n_errors, compares, n_early, exp_early;
    localparam logic [11:0] SEQ_WORDS [8] = '{12'h003, 12'h0A0, 12'hFF3, 12'h000,
        12'h001, 12'h002, 12'h003, 12'h002};

    apmc_ctrl #(.PWRUP_CYCLES(PW)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .chip_select_n(cs_n), .write_n(wr_n), .data_in(din), .conversion_start_n(conv_n),
        .ctrl_reg(ctrl), .power_mode(mode), .powered_down(pdown),
        .track_hold_in_hold(hold), .power_up_busy(busy), .early_conversion(early));
    apmc_host host (.ref_clk(ref_clk), .chip_select_n(cs_n), .write_n(wr_n),
        .data_in(din), .conversion_start_n(conv_n));

    // ************************************************************
    // checking helpers
    // ************************************************************
    function automatic apmc_mode_t decode(input logic [1:0] b);
        case (b)
            2'h0: return APMC_NORMAL;
            2'h1: return APMC_AUTO_SHUT;
            2'h2: return APMC_AUTO_STBY;
            default: return APMC_FULL_SHUT;
        endcase
    endfunction : decode

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic check(input string nm, input logic [11:0] e, input logic [11:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic end_of_test();
        if (n_errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test

    // one write, then every output but early_conversion against the expectation; unselected strobes change nothing
    task automatic do_write(input logic [11:0] d, input logic sel);
        host.write_word(d, sel);
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);  // look away from the edge that launches the outputs
        woke = sel && exp_shut && d[1:0] != 2'h3;
        if (sel) begin
            exp_ctrl = d;
            exp_mode = decode(d[1:0]);
            exp_hold = (d[1:0] == 2'h3) ? 1'b1 : (exp_shut ? 1'b0 : exp_hold);
            exp_shut = d[1:0] == 2'h3;
        end
        check("ctrl_reg", exp_ctrl, ctrl);
        check("power_mode", {8'h00, exp_mode}, {8'h00, mode});
        check("powered_down", {11'h000, exp_shut}, {11'h000, pdown});
        check("hold", {11'h000, exp_hold}, {11'h000, hold});
        check("busy", {11'h000, woke}, {11'h000, busy});
        if (woke) begin
            host.start_conv(0);
            exp_early++;
        end
        repeat (PW + 8) @(posedge ref_clk);
        @(negedge ref_clk);
        check("busy_end", 12'h000, {11'h000, busy});
        if (woke) host.start_conv(1);
    endtask : do_write

    // ************************************************************
    // clock, reset, watchdog and main sequence
    // ************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // counted mid-cycle so the one-cycle pulse is seen once and settled
    always @(negedge ref_clk) if (early === 1'b1) n_early++;

    // the full run needs under 1900 clocks of the 10000 here, so this span only trips on a hang
    initial begin
        #400000;
        n_errors++;
        end_of_test();
    end

    initial begin
        {n_errors, compares, n_early, exp_early} = '0;
        {exp_ctrl, exp_mode, exp_shut, exp_hold} = {12'h000, APMC_NORMAL, 2'b01};
        seed = 32'hBFCF;
        reset_n = 1'b0;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        do_write(12'h000, 1'b0);
        // shutdown, refused wake, shutdown rewrite, wake, every mode, leave to standby
        for (int i = 0; i < 8; i++) do_write(SEQ_WORDS[i], i != 1);
        // reset again mid-run: contents and mode fall back to their defaults
        @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        {exp_ctrl, exp_mode, exp_shut, exp_hold} = {12'h000, APMC_NORMAL, 2'b01};
        do_write(12'h0A0, 1'b0);
        repeat (20) begin
            seed = xs(seed);
            do_write(seed[11:0], seed[12] | seed[13]);
        end
        check("early_count", exp_early[11:0], n_early[11:0]);
        end_of_test();
    end
endmodule : tb_top
